// ==== inc/chan1_regs_pkg.sv ====
// Operation
// - Setup bits 15:6 hold the ten-bit signed phase delay of channel 1 in modulator clock cycles.
// - Setup bit 2 set turns the DC filter off for channel 1 only, clear follows the global setting.
// - Setup bits 1:0 pick the channel 1 input: own pins, shorted, positive test or negative test.
// - The setup register at 0x0e resets to 0x0000.
// - The offset high register holds offset bits 23:8 across all sixteen bits.
// - The offset low register holds offset bits 7:0 in its bits 15:8.
// - The offset high register at 0x0f resets to 0x0000.
// - The gain high register holds gain bits 23:8 across all sixteen bits.
// - The gain high register at 0x11 resets to 0x8000.
// - The gain low register holds gain bits 7:0 in its bits 15:8 and resets to zero.
`default_nettype none
package chan1_regs_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 16;
	localparam logic [7:0]  SETUP_ADDR       = 8'h0e;
	localparam logic [7:0]  OFFSET_HIGH_ADDR = 8'h0f;
	localparam logic [7:0]  OFFSET_LOW_ADDR  = 8'h10;
	localparam logic [7:0]  GAIN_HIGH_ADDR   = 8'h11;
	localparam logic [7:0]  GAIN_LOW_ADDR    = 8'h12;
	localparam logic [15:0] SETUP_RESET      = 16'h0000;
	localparam logic [15:0] OFFSET_HIGH_RESET = 16'h0000;
	localparam logic [15:0] OFFSET_LOW_RESET = 16'h0000;
	localparam logic [15:0] GAIN_HIGH_RESET  = 16'h8000;
	localparam logic [15:0] GAIN_LOW_RESET   = 16'h0000;
	localparam int          PHASE_LSB        = 6;
	localparam int          PHASE_MSB        = 15;
	localparam int          DC_OFF_BIT       = 2;
	localparam int          MUX_LSB          = 0;
	localparam int          MUX_MSB          = 1;
	localparam int          LOW_BYTE_LSB     = 8;
	localparam int          LOW_BYTE_MSB     = 15;
	localparam logic [15:0] SETUP_RW_MASK    = 16'hffc7;
	localparam logic [15:0] LOW_RW_MASK      = 16'hff00;

	typedef enum logic [1:0] {
		INPUT_PINS,
		INPUT_SHORTED,
		INPUT_TEST_POS,
		INPUT_TEST_NEG
	} input_select_t;

	typedef struct packed {
		logic [9:0]    phase_delay;
		logic          dc_filter_off;
		input_select_t input_select;
	} chan1_setup_t;

	typedef struct packed {
		logic [23:0] offset_cal;
		logic [23:0] gain_cal;
	} chan1_cal_t;
endpackage
`default_nettype wire

// ==== hdl/masked_reg.sv ====
`default_nettype none
module masked_reg #(
	parameter int          WIDTH    = 16,
	parameter logic [15:0] RESET_V  = 16'h0000,
	parameter logic [15:0] RW_MASK  = 16'hffff
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic             wr_en_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic      [WIDTH-1:0] value_o
);
	// Masked bits load zero on every write, which matches the reset value of every reserved field
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			value_o <= RESET_V[WIDTH-1:0];
		end else if (wr_en_i) begin
			value_o <= wr_data_i & RW_MASK[WIDTH-1:0];
		end
	end
endmodule
`default_nettype wire

// ==== hdl/chan1_regs.sv ====
`default_nettype none
module chan1_regs (
	input  wire logic                               core_clk_i,
	input  wire logic                               reset_i,
	input  wire logic [chan1_regs_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [chan1_regs_pkg::DATA_W-1:0]  wr_data_i,
	input  wire logic                               wr_i,
	input  wire logic                               rd_i,
	output logic      [chan1_regs_pkg::DATA_W-1:0]  rd_data_o,
	output chan1_regs_pkg::chan1_setup_t            setup_o,
	output chan1_regs_pkg::chan1_cal_t              cal_o
);
	import chan1_regs_pkg::*;

	logic [15:0] setup_r;
	logic [15:0] offset_high_r;
	logic [15:0] offset_low_r;
	logic [15:0] gain_high_r;
	logic [15:0] gain_low_r;
	logic [15:0] rd_nxt;

	masked_reg #(.WIDTH(16), .RESET_V(SETUP_RESET), .RW_MASK(SETUP_RW_MASK)) u_setup (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (wr_i && addr_i == SETUP_ADDR),
		.wr_data_i  (wr_data_i),
		.value_o    (setup_r)
	);
	masked_reg #(.WIDTH(16), .RESET_V(OFFSET_HIGH_RESET), .RW_MASK(16'hffff)) u_offset_high (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (wr_i && addr_i == OFFSET_HIGH_ADDR),
		.wr_data_i  (wr_data_i),
		.value_o    (offset_high_r)
	);
	masked_reg #(.WIDTH(16), .RESET_V(OFFSET_LOW_RESET), .RW_MASK(LOW_RW_MASK)) u_offset_low (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (wr_i && addr_i == OFFSET_LOW_ADDR),
		.wr_data_i  (wr_data_i),
		.value_o    (offset_low_r)
	);
	masked_reg #(.WIDTH(16), .RESET_V(GAIN_HIGH_RESET), .RW_MASK(16'hffff)) u_gain_high (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (wr_i && addr_i == GAIN_HIGH_ADDR),
		.wr_data_i  (wr_data_i),
		.value_o    (gain_high_r)
	);
	masked_reg #(.WIDTH(16), .RESET_V(GAIN_LOW_RESET), .RW_MASK(LOW_RW_MASK)) u_gain_low (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (wr_i && addr_i == GAIN_LOW_ADDR),
		.wr_data_i  (wr_data_i),
		.value_o    (gain_low_r)
	);

	// Unmapped addresses read as zero
	always_comb begin
		if (addr_i == SETUP_ADDR) begin
			rd_nxt = setup_r;
		end else if (addr_i == OFFSET_HIGH_ADDR) begin
			rd_nxt = offset_high_r;
		end else if (addr_i == OFFSET_LOW_ADDR) begin
			rd_nxt = offset_low_r;
		end else if (addr_i == GAIN_HIGH_ADDR) begin
			rd_nxt = gain_high_r;
		end else if (addr_i == GAIN_LOW_ADDR) begin
			rd_nxt = gain_low_r;
		end else begin
			rd_nxt = 16'h0000;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !rd_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			rd_data_o <= rd_nxt;
		end
	end

	// Outputs registered so the datapath sees a new value one cycle after the register updates
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			setup_o <= '0;
		end else begin
			setup_o.phase_delay   <= setup_r[PHASE_MSB:PHASE_LSB];
			setup_o.dc_filter_off <= setup_r[DC_OFF_BIT];
			setup_o.input_select  <= input_select_t'(setup_r[MUX_MSB:MUX_LSB]);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cal_o <= {OFFSET_HIGH_RESET, OFFSET_LOW_RESET[LOW_BYTE_MSB:LOW_BYTE_LSB],
				GAIN_HIGH_RESET, GAIN_LOW_RESET[LOW_BYTE_MSB:LOW_BYTE_LSB]};
		end else begin
			cal_o.offset_cal <= {offset_high_r, offset_low_r[LOW_BYTE_MSB:LOW_BYTE_LSB]};
			cal_o.gain_cal   <= {gain_high_r, gain_low_r[LOW_BYTE_MSB:LOW_BYTE_LSB]};
		end
	end

	property write_reads_back(logic [7:0] a, logic [15:0] m);
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && addr_i == a) ##1 (rd_i && addr_i == a && !wr_i) |=> rd_data_o == ($past(wr_data_i, 2) & m);
	endproperty

	setup_readback_a: assert property (write_reads_back(SETUP_ADDR, SETUP_RW_MASK))
		else $error("setup read back wrong");
	offset_high_readback_a: assert property (write_reads_back(OFFSET_HIGH_ADDR, 16'hffff))
		else $error("offset high read back wrong");
	offset_low_readback_a: assert property (write_reads_back(OFFSET_LOW_ADDR, LOW_RW_MASK))
		else $error("offset low read back wrong");
	gain_low_readback_a: assert property (write_reads_back(GAIN_LOW_ADDR, LOW_RW_MASK))
		else $error("gain low read back wrong");
	gain_reset_a: assert property (@(posedge core_clk_i) $fell(reset_i) |-> ##1 cal_o.gain_cal == 24'h800000)
		else $error("gain reset value wrong");
	offset_reset_a: assert property (@(posedge core_clk_i) $fell(reset_i) |-> cal_o.offset_cal == 24'h000000)
		else $error("offset reset value wrong");
	setup_reset_a: assert property (@(posedge core_clk_i) $fell(reset_i) |-> setup_o == '0)
		else $error("setup reset value wrong");
	phase_field_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && addr_i == SETUP_ADDR) |-> ##2 setup_o.phase_delay == $past(wr_data_i[15:6], 2))
		else $error("phase field wrong");
	dc_field_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && addr_i == SETUP_ADDR) |-> ##2 setup_o.dc_filter_off == $past(wr_data_i[2], 2))
		else $error("dc filter field wrong");
	mux_field_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && addr_i == SETUP_ADDR) |-> ##2 setup_o.input_select == $past(wr_data_i[1:0], 2))
		else $error("input select wrong");
	gain_word_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && addr_i == GAIN_HIGH_ADDR) |-> ##2 cal_o.gain_cal[23:8] == $past(wr_data_i, 2))
		else $error("gain high word wrong");
	idle_read_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i) !rd_i |=> rd_data_o == 16'h0000)
		else $error("read data outside read slot");

	setup_write_c: cover property (@(posedge core_clk_i) wr_i && addr_i == SETUP_ADDR && wr_data_i[2]);
	gain_write_c: cover property (@(posedge core_clk_i) wr_i && addr_i == GAIN_LOW_ADDR ##1 rd_i);
	unmapped_read_c: cover property (@(posedge core_clk_i) rd_i && addr_i == 8'h00);
endmodule
`default_nettype wire

// ==== tb/chan1_regs_tb_top.sv ====
`default_nettype none
module chan1_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import chan1_regs_pkg::*;
	`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
		$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
	logic         core_clk;
	logic         reset;
	logic         wr;
	logic         rd;
	logic [7:0]   addr;
	logic [15:0]  wdata;
	logic [15:0]  rdata;
	chan1_setup_t setup;
	chan1_cal_t   cal;
	int           num_errors = 0;
	int           tests_run = 0;
	chan1_regs dut_u (.core_clk_i(core_clk), .reset_i(reset), .addr_i(addr), .wr_data_i(wdata),
		.wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .setup_o(setup), .cal_o(cal));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic t_reset();
		logic [15:0] d;
		rd_reg(8'h0e, d); `CHK(d, 16'h0000)
		rd_reg(8'h0f, d); `CHK(d, 16'h0000)
		rd_reg(8'h10, d); `CHK(d, 16'h0000)
		rd_reg(8'h11, d); `CHK(d, 16'h8000)
		rd_reg(8'h12, d); `CHK(d, 16'h0000)
		`CHK(setup, 13'h0000)
		`CHK(cal, {24'h000000, 24'h800000})
		$display("reset values done");
	endtask
	task automatic t_setup();
		logic [15:0] d;
		logic [15:0] v;
		for (int k = 0; k < 4; k++) begin
			v = {10'h200 + 10'(k), 3'b111, k[0], 2'(k)};
			wr_reg(8'h0e, v);
			rd_reg(8'h0e, d);
			`CHK(d, v & 16'hffc7)
			`CHK(setup, {v[15:6], v[2], v[1:0]})
		end
		$display("setup fields done");
	endtask
	task automatic t_cal();
		logic [15:0] d;
		wr_reg(8'h0f, 16'ha5c3);
		wr_reg(8'h10, 16'h7eff);
		wr_reg(8'h11, 16'h1234);
		wr_reg(8'h12, 16'hffff);
		rd_reg(8'h0f, d); `CHK(d, 16'ha5c3)
		rd_reg(8'h10, d); `CHK(d, 16'h7e00)
		rd_reg(8'h11, d); `CHK(d, 16'h1234)
		rd_reg(8'h12, d); `CHK(d, 16'hff00)
		`CHK(cal, {24'ha5c37e, 24'h1234ff})
		@(posedge core_clk);
		#1 `CHK(rdata, 16'h0000)
		$display("calibration done");
	endtask
	task automatic t_unmapped();
		logic [15:0] d;
		wr_reg(8'h0d, 16'hffff);
		wr_reg(8'h13, 16'hffff);
		rd_reg(8'h0d, d); `CHK(d, 16'h0000)
		rd_reg(8'h13, d); `CHK(d, 16'h0000)
		rd_reg(8'h0e, d); `CHK(d, 16'h80c7)
		$display("unmapped done");
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded so a stuck handshake cannot hang the run
	initial begin
		repeat (2000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_setup();
		t_cal();
		t_unmapped();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
